// *** netpath_state_machine.sv ***
// Our own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ns
// How it works
// - host path machine sees deactivate always true; only deactivated or initialized.
// - host deactivate is redeinit or disable or squelch-force or in-use.
// - a lane is a host path when its netpath in-use bit is set.
// - media transmit output validity depends on netpath state, lane disable and module reset, never host inputs.
// - receive squelch from synced loss of signal or processing absence, when enabled.
// - transmit squelch only when forced; no automatic transmit squelch ever.
// - netpaths and host paths reconfigure stepped, whatever the stepped setting says.
// - host path machines are separate from netpath machines; changes do not disturb.
// - during management initialization all netpath machines sit in deactivated.
// - netpath leaves deactivated only with module ready and teardown false.
// - undefined machines are removed before newly defined ones start from deactivated.
// - module reset disables media outputs, then resetting removes all machines.
// - a state completes only when every member resource reports done.
// - each netpath machine acts on its own lanes only.
// - teardown is not in use, not ready, low power, or any lane teardown bit.
// - lane teardown and in-use terms OR over host lanes of the netpath.
// - netpath deactivate is teardown or transmit disable or force squelch.
// - disable and force-squelch terms OR over media lanes of the netpath.
// - one teardown register holds one bit per host lane.
// - one write may change several netpaths; all of them react.
// - every lane of a netpath reports that netpath's current state.
// - state changes only set change flags; they never clear any flag.
module netpath_state_machine (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   // avalon-mm slave
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // module state machine
   input  wire logic [2:0]  module_state,
   input  wire logic        low_power_request_signal,
   input  wire logic        module_reset_signal,
   // lane resources
   input  wire logic [7:0]  resource_done,
   input  wire logic [7:0]  rx_los_pin,
   input  wire logic [7:0]  rx_signal_absent,
   // media lane controls and host lane status
   output logic [7:0]       tx_output_enable,
   output logic [7:0]       tx_squelch,
   output logic [7:0]       rx_squelch,
   output logic [7:0]       host_lane_initialized
);
   localparam int L = netpath_pkg::LANES;

   logic [7:0]  lane_teardown_bits_ff;
   logic [7:0]  lane_in_netpath_ff;
   logic [7:0]  media_output_disable_ff;
   logic [7:0]  media_squelch_force_ff;
   logic [23:0] npid_ff;
   logic [7:0]  redeinit_ff;
   logic [7:0]  stepped_reconfig_only_ff;
   logic [7:0]  rx_auto_en_ff;
   logic [7:0]  change_flag_ff;
   logic [31:0] state_status_ff;
   logic [7:0]  hp_init_ff;
   logic [7:0]  los_s1_ff;
   logic [7:0]  los_s2_ff;
   logic [7:0]  los_s3_ff;
   logic [7:0]  los_ff;
   logic [7:0]  tx_en_ff;
   logic [7:0]  tx_sq_ff;
   logic [7:0]  rx_sq_ff;
   logic [31:0] rdata_ff;
   logic        wait_ff;
   netpath_pkg::np_state_t np_state_ff [L];

   // bus decode
   wire        req      = avs_read | avs_write;
   wire        do_write = avs_write & ~wait_ff;
   wire [31:0] be_mask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                           {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   wire [31:0] wmask    = avs_writedata & be_mask;
   wire wr_teardown = do_write & (avs_address == netpath_pkg::OFS_TEARDOWN);
   wire wr_in_use   = do_write & (avs_address == netpath_pkg::OFS_IN_USE);
   wire wr_tx_dis   = do_write & (avs_address == netpath_pkg::OFS_TX_DIS);
   wire wr_tx_sqf   = do_write & (avs_address == netpath_pkg::OFS_TX_SQF);
   wire wr_npid     = do_write & (avs_address == netpath_pkg::OFS_NPID);
   wire wr_redeinit = do_write & (avs_address == netpath_pkg::OFS_REDEINIT);
   wire wr_stepped  = do_write & (avs_address == netpath_pkg::OFS_STEPPED);
   wire wr_rx_auto  = do_write & (avs_address == netpath_pkg::OFS_RX_AUTO);
   wire wr_flags    = do_write & (avs_address == netpath_pkg::OFS_FLAGS);

   function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d);
      merge8 = (old & ~be_mask[7:0]) | d[7:0];
   endfunction

   wire module_is_ready_term = (module_state == netpath_pkg::MOD_READY);
   wire hold_removed = (module_state == netpath_pkg::MOD_MGMT_INIT) |
                       (module_state == netpath_pkg::MOD_RESETTING) |
                       (module_state == netpath_pkg::MOD_RESET);

   // per-netpath terms and machines; lane j belongs to netpath i when its in-use bit is set and npid[j]==i
   logic [7:0] np_defined;
   logic [7:0] netpath_teardown_signal;
   logic [7:0] netpath_deactivate_signal;
   logic [7:0] np_complete;
   logic [7:0] flag_set;
   logic [7:0] np_active;

   genvar gi;
   generate
      for (gi = 0; gi < L; gi++) begin : g_np
         logic [7:0] member;
         logic       lane_teardown_term;
         logic       netpath_in_use_term;
         logic       transmit_disable_term;
         logic       transmit_force_squelch_term;
         netpath_pkg::np_state_t nxt_state;
         genvar gj;
         for (gj = 0; gj < L; gj++) begin : g_m
            assign member[gj] = lane_in_netpath_ff[gj] &
                                (npid_ff[gj*3 +: 3] == 3'(gi));
         end
         // host and media lanes share the lane index within a netpath
         assign lane_teardown_term          = |(member & lane_teardown_bits_ff);
         assign netpath_in_use_term         = |member;
         assign transmit_disable_term       = |(member & media_output_disable_ff);
         assign transmit_force_squelch_term = |(member & media_squelch_force_ff);
         assign np_defined[gi] = member[gi];
         assign netpath_teardown_signal[gi] = ~netpath_in_use_term | ~module_is_ready_term |
                                              low_power_request_signal |
                                              lane_teardown_term;
         assign netpath_deactivate_signal[gi] = netpath_teardown_signal[gi] |
                                                transmit_disable_term |
                                                transmit_force_squelch_term;
         // report only once all member resources are done
         assign np_complete[gi] = &(resource_done | ~member);
         assign np_active[gi] = (np_state_ff[gi] == netpath_pkg::netpath_activated);

         always_comb begin
            nxt_state = np_state_ff[gi];
            case (np_state_ff[gi])
               netpath_pkg::netpath_deactivated:
                  if (!netpath_teardown_signal[gi]) nxt_state = netpath_pkg::netpath_init;
               netpath_pkg::netpath_init:
                  if (np_complete[gi]) nxt_state = netpath_pkg::netpath_initialized;
               netpath_pkg::netpath_initialized:
                  if (netpath_teardown_signal[gi]) nxt_state = netpath_pkg::netpath_deinit;
                  else if (!netpath_deactivate_signal[gi]) nxt_state = netpath_pkg::tx_turn_on;
               netpath_pkg::tx_turn_on:
                  if (np_complete[gi]) nxt_state = netpath_pkg::netpath_activated;
               netpath_pkg::netpath_activated:
                  if (netpath_deactivate_signal[gi]) nxt_state = netpath_pkg::tx_turn_off;
               netpath_pkg::tx_turn_off:
                  if (np_complete[gi]) nxt_state = netpath_pkg::netpath_initialized;
               netpath_pkg::netpath_deinit:
                  if (np_complete[gi]) nxt_state = netpath_pkg::netpath_deactivated;
               default:
                  nxt_state = netpath_pkg::netpath_deactivated;
            endcase
            // a removed or not yet created machine rests in deactivated
            if (hold_removed || !np_defined[gi]) begin
               nxt_state = netpath_pkg::netpath_deactivated;
            end
         end

         // flags only on entry into steady states, and only when not left at once
         assign flag_set[gi] = np_defined[gi] && (nxt_state != np_state_ff[gi]) &&
            ((nxt_state == netpath_pkg::netpath_initialized &&
              !netpath_teardown_signal[gi] && netpath_deactivate_signal[gi]) ||
             (nxt_state == netpath_pkg::netpath_activated && !netpath_deactivate_signal[gi]) ||
             (nxt_state == netpath_pkg::netpath_deactivated && netpath_teardown_signal[gi]));

         // each machine has its own register; no cross coupling
         always_ff @(posedge ref_clk or posedge sys_rst) begin
            if (sys_rst) np_state_ff[gi] <= netpath_pkg::netpath_deactivated;
            else         np_state_ff[gi] <= nxt_state;
         end
      end
   endgenerate

   // per-lane view: state of the owning netpath, flags, host path machines
   logic [31:0] nxt_status;
   logic [7:0]  lane_flag_set;
   logic [7:0]  host_path_deactivate_signal;
   logic [7:0]  nxt_hp_init;
   logic [7:0]  nxt_tx_en;
   generate
      for (gi = 0; gi < L; gi++) begin : g_lane
         wire [2:0] own = npid_ff[gi*3 +: 3];
         wire       in_use = lane_in_netpath_ff[gi];
         assign nxt_status[gi*4 +: 4] = in_use ? {1'b0, np_state_ff[own]} : 4'h0;
         assign lane_flag_set[gi] = in_use & flag_set[own];
         // in-use forces deactivate true for host path lanes
         assign host_path_deactivate_signal[gi] = redeinit_ff[gi] | media_output_disable_ff[gi] |
                                                  media_squelch_force_ff[gi] | in_use;
         // host machine can only be deactivated or initialized; stepped always
         assign nxt_hp_init[gi] = hp_init_ff[gi] ?
                                  ~(redeinit_ff[gi] | ~module_is_ready_term) :
                                  (~redeinit_ff[gi] & module_is_ready_term & in_use);
         // validity of media output never looks at host lane conditions
         assign nxt_tx_en[gi] = in_use & np_active[own] & ~media_output_disable_ff[gi] &
                                ~module_reset_signal;
      end
   endgenerate

   // pin synchroniser for loss of signal; a change counts when stages two and three agree
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         los_s1_ff <= 8'h00_00;
         los_s2_ff <= 8'h00_00;
         los_s3_ff <= 8'h00_00;
         los_ff    <= 8'h00_00;
      end else begin
         los_s1_ff <= rx_los_pin;
         los_s2_ff <= los_s1_ff;
         los_s3_ff <= los_s2_ff;
         los_ff    <= (los_s2_ff & los_s3_ff) | (los_ff & (los_s2_ff | los_s3_ff));
      end
   end

   // rx auto squelch may use processing-layer absence; tx squelch is only forced
   wire [7:0] nxt_rx_sq = rx_auto_en_ff & (los_ff | rx_signal_absent);
   wire [7:0] nxt_tx_sq = media_squelch_force_ff & lane_in_netpath_ff;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_en_ff        <= 8'h00_00;
         tx_sq_ff        <= 8'h00_00;
         rx_sq_ff        <= 8'h00_00;
         hp_init_ff      <= 8'h00_00;
         state_status_ff <= 32'h0000_0000;
      end else begin
         tx_en_ff        <= nxt_tx_en;
         tx_sq_ff        <= nxt_tx_sq;
         rx_sq_ff        <= nxt_rx_sq;
         hp_init_ff      <= nxt_hp_init;
         state_status_ff <= nxt_status;
      end
   end

   // change flags: write one to clear, a new set in the same cycle wins
   wire [7:0] flag_clr = wr_flags ? wmask[7:0] : 8'h00_00;
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) change_flag_ff <= 8'h00_00;
      else         change_flag_ff <= (change_flag_ff & ~flag_clr) | lane_flag_set;
   end

   // control registers; one write can retarget every netpath
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lane_teardown_bits_ff    <= netpath_pkg::RST_TEARDOWN;
         lane_in_netpath_ff       <= netpath_pkg::RST_LANE8;
         media_output_disable_ff  <= netpath_pkg::RST_LANE8;
         media_squelch_force_ff   <= netpath_pkg::RST_LANE8;
         npid_ff                  <= netpath_pkg::RST_NPID;
         redeinit_ff              <= netpath_pkg::RST_LANE8;
         stepped_reconfig_only_ff <= netpath_pkg::RST_LANE8;
         rx_auto_en_ff            <= netpath_pkg::RST_LANE8;
      end else begin
         if (wr_teardown) lane_teardown_bits_ff <= merge8(lane_teardown_bits_ff, wmask);
         if (wr_in_use)   lane_in_netpath_ff <= merge8(lane_in_netpath_ff, wmask);
         if (wr_tx_dis)   media_output_disable_ff <= merge8(media_output_disable_ff, wmask);
         if (wr_tx_sqf)   media_squelch_force_ff <= merge8(media_squelch_force_ff, wmask);
         if (wr_npid)     npid_ff <= (npid_ff & ~be_mask[23:0]) | wmask[23:0];
         if (wr_redeinit) redeinit_ff <= merge8(redeinit_ff, wmask);
         if (wr_stepped)  stepped_reconfig_only_ff <= merge8(stepped_reconfig_only_ff, wmask);
         if (wr_rx_auto)  rx_auto_en_ff <= merge8(rx_auto_en_ff, wmask);
      end
   end

   // read mux; unmapped offsets read zero and ignore writes
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (avs_address)
         netpath_pkg::OFS_TEARDOWN: rd_mux[7:0]  = lane_teardown_bits_ff;
         netpath_pkg::OFS_IN_USE:   rd_mux[7:0]  = lane_in_netpath_ff;
         netpath_pkg::OFS_TX_DIS:   rd_mux[7:0]  = media_output_disable_ff;
         netpath_pkg::OFS_TX_SQF:   rd_mux[7:0]  = media_squelch_force_ff;
         netpath_pkg::OFS_NPID:     rd_mux[23:0] = npid_ff;
         netpath_pkg::OFS_REDEINIT: rd_mux[7:0]  = redeinit_ff;
         netpath_pkg::OFS_STEPPED:  rd_mux[7:0]  = stepped_reconfig_only_ff;
         netpath_pkg::OFS_RX_AUTO:  rd_mux[7:0]  = rx_auto_en_ff;
         netpath_pkg::OFS_NP_STATE: rd_mux = state_status_ff;
         netpath_pkg::OFS_HP_STAT:  rd_mux[15:0] = {host_path_deactivate_signal, hp_init_ff};
         netpath_pkg::OFS_FLAGS:    rd_mux[7:0]  = change_flag_ff;
         default:                   rd_mux = 32'h0000_0000;
      endcase
   end

   // one wait cycle per access, answer on the second edge
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wait_ff  <= 1'b1;
         rdata_ff <= 32'h0000_0000;
      end else begin
         wait_ff <= ~(req & wait_ff);
         if (avs_read && wait_ff) rdata_ff <= rd_mux;
      end
   end

   assign avs_readdata          = rdata_ff;
   assign avs_waitrequest       = wait_ff;
   assign tx_output_enable      = tx_en_ff;
   assign tx_squelch            = tx_sq_ff;
   assign rx_squelch            = rx_sq_ff;
   assign host_lane_initialized = hp_init_ff;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   a_hp_deact_forced: assert property (lane_in_netpath_ff[0] |-> host_path_deactivate_signal[0])
      else $error("host path deactivate not forced");
   a_np_hold_deact: assert property (np_state_ff[0] == netpath_pkg::netpath_deactivated &&
      !module_is_ready_term |=> np_state_ff[0] == netpath_pkg::netpath_deactivated)
      else $error("netpath left deactivated while module not ready");
   a_np_mgmt_init: assert property (module_state == netpath_pkg::MOD_MGMT_INIT
      |=> np_state_ff[1] == netpath_pkg::netpath_deactivated)
      else $error("netpath not deactivated in management init");
   a_np_reset_kill: assert property (module_reset_signal |=> tx_en_ff == 8'h00_00)
      else $error("media output on during module reset");
   a_np_wait_done: assert property (np_state_ff[0] == netpath_pkg::netpath_init && !np_complete[0] &&
      !hold_removed && np_defined[0] |=> np_state_ff[0] == netpath_pkg::netpath_init)
      else $error("init left before resources done");
   a_np_teardown: assert property (np_state_ff[0] == netpath_pkg::netpath_initialized &&
      netpath_teardown_signal[0] && np_defined[0] && !hold_removed
      |=> np_state_ff[0] == netpath_pkg::netpath_deinit)
      else $error("initialized did not go to deinit");
   a_tx_valid: assert property (tx_en_ff[0] |-> $past(np_active[npid_ff[2:0]]))
      else $error("tx enabled outside activated");
   a_tx_no_auto: assert property (tx_sq_ff[2] |-> $past(media_squelch_force_ff[2]))
      else $error("tx squelch without force");
   a_rx_squelch: assert property (rx_auto_en_ff[3] && los_ff[3] |=> rx_sq_ff[3])
      else $error("rx squelch missed loss of signal");
   a_flag_kept: assert property (change_flag_ff[0] && !(wr_flags && avs_writedata[0] &&
      avs_byteenable[0]) |=> change_flag_ff[0])
      else $error("flag lost without software clear");
   a_status_lane: assert property (lane_in_netpath_ff[1] && $stable(npid_ff) && $stable(lane_in_netpath_ff)
      |=> state_status_ff[6:4] == $past(np_state_ff[npid_ff[5:3]]))
      else $error("lane status does not follow its netpath");
   // exit conditions that low power and the per-lane control bits must trigger
   a_np_lowpwr_off: assert property (np_state_ff[0] == netpath_pkg::netpath_activated &&
      low_power_request_signal && np_defined[0] && !hold_removed
      |=> np_state_ff[0] == netpath_pkg::tx_turn_off)
      else $error("low power did not turn transmit off");
   a_np_disable_off: assert property (np_state_ff[0] == netpath_pkg::netpath_activated &&
      media_output_disable_ff[1] && lane_in_netpath_ff[1] && npid_ff[5:3] == 3'h0 &&
      np_defined[0] && !hold_removed |=> np_state_ff[0] == netpath_pkg::tx_turn_off)
      else $error("output disable did not turn transmit off");
   a_np_lane_down: assert property (np_state_ff[4] == netpath_pkg::netpath_activated &&
      lane_teardown_bits_ff[7] && lane_in_netpath_ff[7] && npid_ff[23:21] == 3'h4 &&
      np_defined[4] && !hold_removed |=> np_state_ff[4] == netpath_pkg::tx_turn_off)
      else $error("lane teardown did not turn transmit off");
   a_np_init_go: assert property (np_state_ff[0] == netpath_pkg::netpath_deactivated &&
      !netpath_teardown_signal[0] && np_defined[0] && !hold_removed
      |=> np_state_ff[0] == netpath_pkg::netpath_init)
      else $error("netpath did not start init");
   a_np_removed: assert property (hold_removed || !np_defined[4]
      |=> np_state_ff[4] == netpath_pkg::netpath_deactivated)
      else $error("removed netpath not deactivated");
   a_tx_sq_forced: assert property (media_squelch_force_ff[6] && lane_in_netpath_ff[6]
      |=> tx_sq_ff[6])
      else $error("forced tx squelch missing");
   a_hp_redeinit: assert property (redeinit_ff[0]
      |=> !hp_init_ff[0])
      else $error("host path stayed initialized on redeinit");

   c_activated: cover property (np_state_ff[0] == netpath_pkg::netpath_activated);
   c_tx_off: cover property (np_state_ff[4] == netpath_pkg::tx_turn_off);
   c_deinit: cover property (np_state_ff[0] == netpath_pkg::netpath_deinit ##1
      np_state_ff[0] == netpath_pkg::netpath_deactivated);
   c_flag: cover property ($rose(change_flag_ff[0]));
   c_read: cover property (avs_read && !wait_ff);
endmodule

// *** netpath_pkg.sv ***
package netpath_pkg;
   localparam int LANES = 8;
   localparam int NPID_W = 3;
   // register byte offsets
   localparam logic [5:0] OFS_TEARDOWN = 6'h00;
   localparam logic [5:0] OFS_IN_USE   = 6'h04;
   localparam logic [5:0] OFS_TX_DIS   = 6'h08;
   localparam logic [5:0] OFS_TX_SQF   = 6'h0C;
   localparam logic [5:0] OFS_NPID     = 6'h10;
   localparam logic [5:0] OFS_REDEINIT = 6'h14;
   localparam logic [5:0] OFS_STEPPED  = 6'h18;
   localparam logic [5:0] OFS_RX_AUTO  = 6'h1C;
   localparam logic [5:0] OFS_NP_STATE = 6'h20;
   localparam logic [5:0] OFS_HP_STAT  = 6'h24;
   localparam logic [5:0] OFS_FLAGS    = 6'h28;
   // reset values
   localparam logic [7:0]  RST_TEARDOWN = 8'h00_FF;
   localparam logic [7:0]  RST_LANE8    = 8'h00_00;
   localparam logic [23:0] RST_NPID     = 24'h00_0000;
   // status field layout
   localparam int STATE_NIB = 4;
   localparam int HP_DEACT_POS = 8;
   // module state codes, driven by the module state machine
   localparam logic [2:0] MOD_RESET     = 3'h0;
   localparam logic [2:0] MOD_MGMT_INIT = 3'h1;
   localparam logic [2:0] MOD_LOW_POWER = 3'h2;
   localparam logic [2:0] MOD_READY     = 3'h3;
   localparam logic [2:0] MOD_FAULT     = 3'h4;
   localparam logic [2:0] MOD_RESETTING = 3'h5;
   typedef enum logic [2:0] {
      netpath_deactivated = 3'h0,
      netpath_init        = 3'h1,
      netpath_initialized = 3'h3,
      tx_turn_on          = 3'h2,
      netpath_activated   = 3'h6,
      tx_turn_off         = 3'h7,
      netpath_deinit      = 3'h5
   } np_state_t;
endpackage

// *** lane_resources.sv ***
`timescale 1ns/1ns
module lane_resources (
   // clock
   input  wire logic       ref_clk,
   // bench control: a held lane never finishes its action
   input  wire logic [7:0] hold,
   // completion towards the block
   output logic      [7:0] resource_done
);
   // one cycle late, so no action ever completes on the edge that starts it
   always_ff @(posedge ref_clk) begin
      resource_done <= ~hold;
   end
endmodule

// *** testbench.sv ***
`timescale 1ns/1ns
module testbench;
   logic        ref_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
   logic        low_power_request_signal, module_reset_signal;
   logic [5:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [2:0]  module_state;
   logic [7:0]  hold, resource_done, rx_los_pin, rx_signal_absent;
   logic [7:0]  tx_output_enable, tx_squelch, rx_squelch, host_lane_initialized;
   int          n_errors = 0;
   int          checks = 0;
   netpath_state_machine i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .module_state(module_state),
      .low_power_request_signal(low_power_request_signal), .module_reset_signal(module_reset_signal),
      .resource_done(resource_done), .rx_los_pin(rx_los_pin), .rx_signal_absent(rx_signal_absent),
      .tx_output_enable(tx_output_enable), .tx_squelch(tx_squelch), .rx_squelch(rx_squelch),
      .host_lane_initialized(host_lane_initialized));
   lane_resources i_res (.ref_clk(ref_clk), .hold(hold), .resource_done(resource_done));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task test_done();
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // entered just after a rising edge; returns one edge after release
   task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      int n;
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
      if (n >= 20) n_errors++;
   endtask
   task wait_state(input logic [31:0] exp);
      int k;
      k = 0;
      do begin
         bus(1'b0, netpath_pkg::OFS_NP_STATE, 32'h0000_0000);
         k++;
      end while (rd !== exp && k < 40);
      check(rd, exp);
   endtask
   // lanes 0..3 form the low netpath, lanes 4..7 the high one
   function automatic logic [31:0] st(input netpath_pkg::np_state_t a, input netpath_pkg::np_state_t b);
      st = {{4{1'b0, b}}, {4{1'b0, a}}};
   endfunction
   task t_reset();
      bus(1'b0, netpath_pkg::OFS_TEARDOWN, 32'h0000_0000);
      check(rd, {24'h00_0000, netpath_pkg::RST_TEARDOWN});
      bus(1'b0, 6'h3C, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      check({24'h00_0000, tx_output_enable}, 32'h0000_0000);
   endtask
   task t_up();
      bus(1'b1, netpath_pkg::OFS_IN_USE, 32'h0000_00FF);
      bus(1'b1, netpath_pkg::OFS_NPID, 32'h0092_4000);
      bus(1'b1, netpath_pkg::OFS_TEARDOWN, 32'h0000_0000);
      repeat (10) @(posedge ref_clk);
      wait_state(32'h0000_0000);
      hold <= 8'h08;
      module_state <= netpath_pkg::MOD_READY;
      wait_state(st(netpath_pkg::netpath_init, netpath_pkg::netpath_activated));
      check({24'h00_0000, tx_output_enable}, 32'h0000_00F0);
      check({24'h00_0000, host_lane_initialized}, 32'h0000_00FF);
      bus(1'b0, netpath_pkg::OFS_HP_STAT, 32'h0000_0000);
      check(rd & 32'h0000_FF00, 32'h0000_FF00);
      hold <= 8'h00;
      wait_state(st(netpath_pkg::netpath_activated, netpath_pkg::netpath_activated));
      check({24'h00_0000, tx_output_enable}, 32'h0000_00FF);
      bus(1'b0, netpath_pkg::OFS_FLAGS, 32'h0000_0000);
      check(rd, 32'h0000_00FF);
      bus(1'b1, netpath_pkg::OFS_FLAGS, 32'h0000_00FF);
      bus(1'b0, netpath_pkg::OFS_FLAGS, 32'h0000_0000);
      check(rd, 32'h0000_0000);
   endtask
   task t_one_down();
      bus(1'b1, netpath_pkg::OFS_TEARDOWN, 32'h0000_0080);
      wait_state(st(netpath_pkg::netpath_activated, netpath_pkg::netpath_deactivated));
      check({24'h00_0000, tx_output_enable}, 32'h0000_000F);
      bus(1'b0, netpath_pkg::OFS_FLAGS, 32'h0000_0000);
      check(rd, 32'h0000_00F0);
      bus(1'b1, netpath_pkg::OFS_TEARDOWN, 32'h0000_0000);
      wait_state(st(netpath_pkg::netpath_activated, netpath_pkg::netpath_activated));
      low_power_request_signal <= 1'b1;
      wait_state(32'h0000_0000);
      check({24'h00_0000, tx_output_enable}, 32'h0000_0000);
      low_power_request_signal <= 1'b0;
      wait_state(st(netpath_pkg::netpath_activated, netpath_pkg::netpath_activated));
   endtask
   task t_disable();
      bus(1'b1, netpath_pkg::OFS_TX_DIS, 32'h0000_0002);
      wait_state(st(netpath_pkg::netpath_initialized, netpath_pkg::netpath_activated));
      check({24'h00_0000, tx_output_enable}, 32'h0000_00F0);
      bus(1'b1, netpath_pkg::OFS_TX_DIS, 32'h0000_0000);
      bus(1'b1, netpath_pkg::OFS_TX_SQF, 32'h0000_0040);
      wait_state(st(netpath_pkg::netpath_activated, netpath_pkg::netpath_initialized));
      check({24'h00_0000, tx_squelch}, 32'h0000_0040);
      bus(1'b1, netpath_pkg::OFS_TX_SQF, 32'h0000_0000);
      wait_state(st(netpath_pkg::netpath_activated, netpath_pkg::netpath_activated));
   endtask
   task t_squelch();
      bus(1'b1, netpath_pkg::OFS_RX_AUTO, 32'h0000_00FF);
      bus(1'b1, netpath_pkg::OFS_REDEINIT, 32'h0000_0001);
      rx_los_pin <= 8'h09;
      rx_signal_absent <= 8'h20;
      repeat (8) @(posedge ref_clk);
      check({24'h00_0000, host_lane_initialized}, 32'h0000_00FE);
      check({24'h00_0000, rx_squelch}, 32'h0000_0029);
      check({24'h00_0000, tx_squelch}, 32'h0000_0000);
      check({24'h00_0000, tx_output_enable}, 32'h0000_00FF);
      rx_los_pin <= 8'h00;
      rx_signal_absent <= 8'h00;
   endtask
   task t_mod_reset();
      module_reset_signal <= 1'b1;
      module_state <= netpath_pkg::MOD_RESETTING;
      repeat (3) @(posedge ref_clk);
      check({24'h00_0000, tx_output_enable}, 32'h0000_0000);
      wait_state(32'h0000_0000);
   endtask
   initial begin
      sys_rst = 1'b1;
      {avs_read, avs_write, low_power_request_signal, module_reset_signal} = 4'h0;
      avs_address = 6'h00;
      avs_writedata = 32'h0000_0000;
      module_state = netpath_pkg::MOD_MGMT_INIT;
      {hold, rx_los_pin, rx_signal_absent} = 24'h00_0000;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      t_reset();
      module_state <= netpath_pkg::MOD_LOW_POWER;
      t_up();
      t_one_down();
      t_disable();
      t_squelch();
      t_mod_reset();
      test_done();
   end
   // the whole sequence needs well under 5000 cycles
   initial begin
      #200000;
      n_errors++;
      test_done();
   end
endmodule
